/* hdl/amc_pkg.sv */
`default_nettype none
package amc_pkg;
  localparam int          NUM_AREAS   = 8;
  // Area slots in register and output order
  localparam int          AREA_0      = 0;
  localparam int          AREA_2      = 1;
  localparam int          AREA_3      = 2;
  localparam int          AREA_4      = 3;
  localparam int          AREA_5A     = 4;
  localparam int          AREA_5B     = 5;
  localparam int          AREA_6A     = 6;
  localparam int          AREA_6B     = 7;

  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  BCR_BASE    = 8'h00;
  localparam logic [7:0]  WCR_BASE    = 8'h20;
  localparam logic [7:0]  STATUS_OFF  = 8'h40;

  localparam int          KIND_LSB    = 12;
  localparam int          KIND_MSB    = 14;
  localparam int          WIDTH_LSB   = 9;
  localparam int          WIDTH_MSB   = 10;
  // Bits 31:16 kept as plain storage, 15, 11 and 8:0 read zero
  localparam logic [31:0] BCR_WR_MASK = 32'hFFFF_7600;
  localparam logic [31:0] BCR_RESET   = 32'h0000_0600;
  localparam logic [31:0] WCR_RESET   = 32'h0000_0500;

  localparam logic [2:0]  KIND_NORMAL = 3'h0;
  localparam logic [2:0]  KIND_BURST  = 3'h1;
  localparam logic [2:0]  KIND_MUXIO  = 3'h2;
  localparam logic [2:0]  KIND_BYTESEL = 3'h3;
  localparam logic [2:0]  KIND_SDRAM  = 3'h4;
  localparam int          KINDS       = 5;

  localparam logic [1:0]  WIDTH_8     = 2'h1;
  localparam logic [1:0]  WIDTH_16    = 2'h2;
  localparam logic [1:0]  WIDTH_32    = 2'h3;

  // Wait-control field positions for the non-SDRAM layout
  localparam int          WC_SETUP_LSB = 11;
  localparam int          WC_WAIT_LSB  = 7;
  localparam int          WC_MASK_BIT  = 6;
  localparam int          WC_HOLD_LSB  = 0;
endpackage : amc_pkg
`default_nettype wire

/* hdl/amc_area_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module amc_area_decode #(
  parameter bit WIDE_OK = 1'b1                 // Area may use 32-bit width
) (
  input  wire logic [2:0] kind_code,           // Stored memory-kind field
  input  wire logic [1:0] width_code,          // Effective bus-width code
  output logic      [4:0] kind_onehot,         // Normal,burst,mux,bytesel,sdram
  output logic      [2:0] width_onehot         // 8,16,32 bit; zero if barred
);
  always_comb begin
    kind_onehot = 5'h00;
    unique case (kind_code)
      amc_pkg::KIND_NORMAL:  kind_onehot = 5'h01;
      amc_pkg::KIND_BURST:   kind_onehot = 5'h02;
      amc_pkg::KIND_MUXIO:   kind_onehot = 5'h04;
      amc_pkg::KIND_BYTESEL: kind_onehot = 5'h08;
      amc_pkg::KIND_SDRAM:   kind_onehot = 5'h10;
      default:               kind_onehot = 5'h00;
    endcase
  end

  always_comb begin
    width_onehot = 3'h0;
    unique case (width_code)
      amc_pkg::WIDTH_8:  width_onehot = 3'h1;
      amc_pkg::WIDTH_16: width_onehot = 3'h2;
      amc_pkg::WIDTH_32: width_onehot = WIDE_OK ? 3'h4 : 3'h0;
      default:           width_onehot = 3'h0;
    endcase
  end
endmodule : amc_area_decode
`default_nettype wire

/* hdl/amc_wait_fields.sv */
`timescale 1ns/1ns
`default_nettype none
module amc_wait_fields (
  input  wire logic [4:0]  kind_onehot,        // Decoded memory kind
  input  wire logic [31:0] wait_reg,           // Stored wait-control word
  output logic      [3:0]  access_wait,        // Access wait code
  output logic      [1:0]  setup_delay,        // Address to strobe delay
  output logic      [1:0]  hold_delay,         // Strobe to address delay
  output logic             ext_wait_ignore     // External wait masked
);
  logic async_layout;

  // SDRAM and barred kinds have no fields here; all four outputs are driven zero for them
  assign async_layout = |kind_onehot[3:0];

  always_comb begin
    access_wait     = 4'h0;
    setup_delay     = 2'h0;
    hold_delay      = 2'h0;
    ext_wait_ignore = 1'b0;
    if (async_layout) begin
      access_wait     = wait_reg[amc_pkg::WC_WAIT_LSB +: 4];
      setup_delay     = wait_reg[amc_pkg::WC_SETUP_LSB +: 2];
      hold_delay      = wait_reg[amc_pkg::WC_HOLD_LSB +: 2];
      ext_wait_ignore = wait_reg[amc_pkg::WC_MASK_BIT];
    end
  end
endmodule : amc_wait_fields
`default_nettype wire

/* hdl/amc_area_config.sv */
// Contract
// - Decode memory kind; codes 101-111 barred.
// - Areas 2,3,4,5A width 8/16/32; 00 barred.
// - Areas 5B,6A,6B width 8/16; 00,11 barred.
// - Area 0 width from pin, field ignored.
// - Reserved control bits read zero.
// - Wait register layout follows memory kind.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module amc_area_config (
  input  wire logic        core_clk,            // 100 MHz clock
  input  wire logic        sys_rst,             // Sync reset, active high
  input  wire logic [7:0]  reg_addr,            // Register byte address
  input  wire logic [31:0] reg_wdata,           // Write data
  input  wire logic        reg_wr,              // Write strobe
  input  wire logic        reg_rd,              // Read strobe
  output logic      [31:0] reg_rdata,           // Read data, cycle after rd
  input  wire logic [1:0]  area_zero_width_pin, // Area 0 width strap pin
  output logic      [39:0] area_kind_onehot,    // 5 bits per area
  output logic      [23:0] area_width_onehot,   // 3 bits per area
  output logic      [31:0] area_access_wait,    // 4 bits per area
  output logic      [15:0] area_setup_delay,    // 2 bits per area
  output logic      [15:0] area_hold_delay,     // 2 bits per area
  output logic      [7:0]  area_ext_wait_ignore // 1 bit per area
);
  localparam int N = amc_pkg::NUM_AREAS;

  logic [31:0] bus_ctrl  [N];
  logic [31:0] wait_ctrl [N];
  logic [1:0]  pin_meta;
  logic [1:0]  pin_sync;
  logic [31:0] next_rdata;

  logic [39:0] next_kind;
  logic [23:0] next_width;
  logic [31:0] next_wait;
  logic [15:0] next_setup;
  logic [15:0] next_hold;
  logic [7:0]  next_ignore;

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] base,
                               input int         idx);
    logic [7:0] off;
    off = base + 8'(idx * 4);
    return addr == off;
  endfunction : hit

  function automatic logic wide_ok(input int idx);
    return idx < amc_pkg::AREA_5B;
  endfunction : wide_ok

  // Strap pin comes from outside the clock domain
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= area_zero_width_pin;
      pin_sync <= pin_meta;
    end
  end

  // Control words: barred codes are kept as written, no flag is raised
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < N; i++) begin
        bus_ctrl[i] <= amc_pkg::BCR_RESET;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < N; i++) begin
        if (hit(reg_addr, amc_pkg::BCR_BASE, i)) begin
          bus_ctrl[i] <= reg_wdata & amc_pkg::BCR_WR_MASK;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < N; i++) begin
        wait_ctrl[i] <= amc_pkg::WCR_RESET;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < N; i++) begin
        if (hit(reg_addr, amc_pkg::WCR_BASE, i)) begin
          wait_ctrl[i] <= reg_wdata;
        end
      end
    end
  end

  // Unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < N; i++) begin
      if (hit(reg_addr, amc_pkg::BCR_BASE, i)) begin
        next_rdata = bus_ctrl[i];
      end
      if (hit(reg_addr, amc_pkg::WCR_BASE, i)) begin
        next_rdata = wait_ctrl[i];
      end
    end
    if (reg_addr == amc_pkg::STATUS_OFF) begin
      next_rdata = {30'h0000_0000, pin_sync};
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Per-area decode; wait fields follow the kind decoded just above them,
  // so a control write takes effect on the wait layout at once
  for (genvar g = 0; g < N; g++) begin : g_area
    logic [1:0] width_code;
    logic [4:0] kind_oh;
    logic [2:0] width_oh;

    // Area 0 ignores its stored width field
    assign width_code = (g == amc_pkg::AREA_0) ? pin_sync
                      : bus_ctrl[g][amc_pkg::WIDTH_MSB:amc_pkg::WIDTH_LSB];

    amc_area_decode #(
      .WIDE_OK      (wide_ok(g))
    ) u_decode (
      .kind_code    (bus_ctrl[g][amc_pkg::KIND_MSB:amc_pkg::KIND_LSB]),
      .width_code   (width_code),
      .kind_onehot  (kind_oh),
      .width_onehot (width_oh)
    );

    amc_wait_fields u_wait (
      .kind_onehot     (kind_oh),
      .wait_reg        (wait_ctrl[g]),
      .access_wait     (next_wait[g*4 +: 4]),
      .setup_delay     (next_setup[g*2 +: 2]),
      .hold_delay      (next_hold[g*2 +: 2]),
      .ext_wait_ignore (next_ignore[g])
    );

    assign next_kind[g*5 +: 5]  = kind_oh;
    assign next_width[g*3 +: 3] = width_oh;
  end

  // Outputs are registered: one cycle after the register write
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      area_kind_onehot     <= 40'h00_0000_0000;
      area_width_onehot    <= 24'h00_0000;
      area_access_wait     <= 32'h0000_0000;
      area_setup_delay     <= 16'h0000;
      area_hold_delay      <= 16'h0000;
      area_ext_wait_ignore <= 8'h00;
    end else begin
      area_kind_onehot     <= next_kind;
      area_width_onehot    <= next_width;
      area_access_wait     <= next_wait;
      area_setup_delay     <= next_setup;
      area_hold_delay      <= next_hold;
      area_ext_wait_ignore <= next_ignore;
    end
  end
endmodule : amc_area_config
`default_nettype wire

/* sim/amc_strap_model.sv */
`timescale 1ns/1ns
`default_nettype none
module amc_strap_model (
  input  wire logic [1:0] strap_code,         // Board strap level
  output logic      [1:0] area_zero_width_pin // Pin seen by block
);
  // Wired level; the delay keeps changes off the clock edge
  assign #3 area_zero_width_pin = strap_code;
endmodule : amc_strap_model
`default_nettype wire

/* sim/amc_area_config_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module amc_area_config_asserts (
  input wire logic        core_clk,            // Clock
  input wire logic        sys_rst,             // Reset
  input wire logic [7:0]  reg_addr,            // Address
  input wire logic [31:0] reg_wdata,           // Write data
  input wire logic        reg_wr,              // Write
  input wire logic        reg_rd,              // Read
  input wire logic [31:0] reg_rdata,           // Read data
  input wire logic [1:0]  area_zero_width_pin, // Strap
  input wire logic [39:0] area_kind_onehot,    // Kinds
  input wire logic [23:0] area_width_onehot,   // Widths
  input wire logic [31:0] area_access_wait,    // Waits
  input wire logic [15:0] area_setup_delay,    // Setups
  input wire logic [15:0] area_hold_delay,     // Holds
  input wire logic [7:0]  area_ext_wait_ignore // Masks
);
  logic [2:0] since_rst;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  function automatic logic [4:0] kd(input logic [2:0] k);
    return (k < 3'h5) ? (5'h1 << k) : 5'h0;
  endfunction : kd
  function automatic logic [2:0] wd(input logic [1:0] w, input logic x);
    return (w == 2'h0 || (w == 2'h3 && !x)) ? 3'h0 : (3'h1 << (w - 2'h1));
  endfunction : wd
  // The strap synchroniser holds zero for a few edges after reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) since_rst <= 3'h0;
    else if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
  end
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_store;
    reg_wr && reg_addr < 8'h20 && reg_addr[1:0] == 2'h0 ##1
      reg_rd && reg_addr == $past(reg_addr)
      |=> reg_rdata == ($past(reg_wdata, 2) & amc_pkg::BCR_WR_MASK);
  endproperty
  a_store: assert property (p_store) else $error("readback");
  property p_kind1;
    reg_wr && reg_addr == 8'h04 ##1 !(reg_wr && reg_addr == 8'h04)
      |=> area_kind_onehot[9:5] == kd($past(reg_wdata[14:12], 2));
  endproperty
  a_kind1: assert property (p_kind1) else $error("kind decode");
  property p_width1;
    reg_wr && reg_addr == 8'h04 ##1 !(reg_wr && reg_addr == 8'h04)
      |=> area_width_onehot[5:3] == wd($past(reg_wdata[10:9], 2), 1'b1);
  endproperty
  a_width1: assert property (p_width1) else $error("wide decode");
  property p_width5;
    reg_wr && reg_addr == 8'h14 ##1 !(reg_wr && reg_addr == 8'h14)
      |=> area_width_onehot[17:15] == wd($past(reg_wdata[10:9], 2), 1'b0);
  endproperty
  a_width5: assert property (p_width5) else $error("narrow decode");
  property p_zero_pin;
    (since_rst > 3'h4 && $stable(area_zero_width_pin)) [*4]
      |-> area_width_onehot[2:0] == wd(area_zero_width_pin, 1'b1);
  endproperty
  a_zero_pin: assert property (p_zero_pin) else $error("strap");
  property p_wait3;
    reg_wr && reg_addr == 8'h2C ##1 !(reg_wr && reg_addr == 8'h2C)
      |=> area_kind_onehot[18:15] == 4'h0 || (area_access_wait[15:12]
      == $past(reg_wdata[10:7], 2) && area_hold_delay[7:6]
      == $past(reg_wdata[1:0], 2));
  endproperty
  a_wait3: assert property (p_wait3) else $error("wait fields");
  property p_sdram1;
    area_kind_onehot[9] |-> area_access_wait[7:4] == 4'h0 &&
      area_setup_delay[3:2] == 2'h0 && !area_ext_wait_ignore[1];
  endproperty
  a_sdram1: assert property (p_sdram1) else $error("sdram fields");
endmodule : amc_area_config_asserts
bind amc_area_config amc_area_config_asserts amc_area_config_asserts_inst (
  .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .area_zero_width_pin, .area_kind_onehot, .area_width_onehot,
  .area_access_wait, .area_setup_delay, .area_hold_delay,
  .area_ext_wait_ignore);
`default_nettype wire

/* sim/amc_area_config_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module amc_area_config_tb;
  logic        core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0;
  logic        reg_rd = 1'b0, rd_seen = 1'b0;
  logic [7:0]  reg_addr = 8'h00, area_ext_wait_ignore, ka;
  logic [31:0] reg_wdata = 32'h0, seed = 32'hB, d, reg_rdata;
  logic [31:0] area_access_wait, exp_q[$];
  logic [1:0]  strap_code = 2'h2;
  wire logic [1:0] area_zero_width_pin;
  logic [39:0] area_kind_onehot;
  logic [23:0] area_width_onehot;
  logic [15:0] area_setup_delay, area_hold_delay;
  int          fails = 0, n_compared = 0, w;
  // Legal map: burst 0, SDRAM 2 and 3 at 16 bits, byte-select 4, mux 5B
  logic [31:0] cfg [8] = '{32'h0000_1400, 32'h0000_4400, 32'h0000_4400,
    32'h0000_3200, 32'h0000_0400, 32'h0000_2400, 32'h0000_0200,
    32'h0000_0400};
  amc_area_config amc_area_config_inst (.core_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .area_zero_width_pin,
    .area_kind_onehot, .area_width_onehot, .area_access_wait,
    .area_setup_delay, .area_hold_delay, .area_ext_wait_ignore);
  amc_strap_model amc_strap_model_inst (.strap_code, .area_zero_width_pin);
  initial forever #5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Write, then read the same place back with no gap
  task automatic wr(input logic [7:0] a, input logic [31:0] v, e);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_seen) check(reg_rdata, exp_q.pop_front());
  end
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      rd(8'(4 * s), 32'h0000_0600);
      rd(8'(8'h20 + 4 * s), 32'h0000_0500);
    end
    check(32'(area_width_onehot[23:3]), 32'h0000_0924);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      w = k % 4;
      // Each kind lands only where it is allowed; codes 5-7 are barred
      ka = (k == 1) ? 8'h0C : (k == 2 || k == 3) ? 8'h14 : 8'h04;
      d = {seed[31:16], 1'b1, 3'(k), 1'b1, 2'h2, 9'h1FF};
      wr(ka, d, d & amc_pkg::BCR_WR_MASK);
      check(32'(area_kind_onehot[5 * ka[4:2] +: 5]),
            k < 5 ? 32'h1 << k : 32'h0);
      d = {seed[31:16], 1'b1, 3'h0, 1'b1, 2'(w), 9'h1FF};
      wr(8'h04, d, d & amc_pkg::BCR_WR_MASK);
      wr(8'h14, d, d & amc_pkg::BCR_WR_MASK);
      check(32'(area_kind_onehot[29:25]), 32'h1);
      check(32'(area_width_onehot[5:3]), w > 0 ? 32'h1 << (w - 1) : 0);
      check(32'(area_width_onehot[17:15]),
            (w == 1 || w == 2) ? 32'h1 << (w - 1) : 32'h0);
    end
    // Area 0 control field written opposite to the strap
    for (int p = 0; p < 4; p++) begin
      strap_code <= 2'(p);
      wr(8'h00, 32'(~p & 3) << 9, 32'(~p & 3) << 9);
      repeat (4) @(posedge core_clk);
      rd(8'h40, 32'(p));
      #1;
      check(32'(area_width_onehot[2:0]), p > 0 ? 32'h1 << (p - 1) : 0);
    end
    // Legal map, control words before wait words, 8- or 16-bit only
    strap_code <= 2'h2;
    for (int s = 0; s < 8; s++) begin
      wr(8'(4 * s), cfg[s], cfg[s]);
    end
    check(32'(area_kind_onehot[19:0]),
          32'({5'h08, 5'h10, 5'h10, 5'h02}));
    check(32'(area_kind_onehot[39:20]),
          32'({5'h01, 5'h01, 5'h04, 5'h01}));
    check(32'(area_width_onehot),
          32'({3'h2, 3'h1, 3'h2, 3'h2, 3'h1, 3'h2, 3'h2, 3'h2}));
    seed = lfsr(seed);
    wr(8'h2C, seed, seed);
    check({area_access_wait[15:12], area_setup_delay[7:6],
           area_hold_delay[7:6], area_ext_wait_ignore[3]},
          {seed[10:7], seed[12:11], seed[1:0], seed[6]});
    seed = lfsr(seed);
    wr(8'h28, seed, seed);
    check({area_access_wait[11:8], area_setup_delay[5:4],
           area_hold_delay[5:4], area_ext_wait_ignore[2]}, 32'h0);
    wr(8'h44, 32'hFFFF_FFFF, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF, 32'h2);
    repeat (3) @(posedge core_clk);
    print_verdict();
  end
endmodule : amc_area_config_tb
`default_nettype wire
